/* File: logic/fsp_self_program.sv */
// Flash self-programming control: register, store/load windows, operations.
// Assumes the core stalls on core_stall and the flash macro follows
// flash_cmd while its op is not idle, reading the buffer via flash_buf_addr.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fsp_self_program #(
  parameter int unsigned OP_TICKS = fsp_pkg::FSP_OP_MIN_TICKS
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Register port
  input  wire fsp_pkg::fsp_reg_req_t  reg_req,
  output logic [7:0]                  reg_rdata,
  // Core store/load requests and answers
  input  wire fsp_pkg::fsp_core_req_t core_req,
  output logic                        core_stall,
  output logic                        load_valid,
  output logic [7:0]                  load_data,
  // EEPROM status
  input  wire logic                   eeprom_write_busy_flag,
  input  wire logic                   eeprom_write_start,
  // Oscillator tick
  input  wire logic                   osc_tick,
  // Fuses and nonvolatile lock bits
  input  wire logic                   self_program_fuse,
  input  wire logic [7:0]             fuse_low,
  input  wire logic [7:0]             fuse_high,
  input  wire logic [1:0]             lock_nv,
  input  wire logic                   chip_erase,
  // Flash macro
  output fsp_pkg::fsp_flash_cmd_t     flash_cmd,
  output logic [1:0]                  lock_bits,
  output logic                        ext_prog_lock,
  output logic                        ext_read_lock,
  input  wire logic [fsp_pkg::FSP_WORD_BITS-1:0] flash_buf_addr,
  output logic [15:0]                 flash_buf_data
);
  import fsp_pkg::*;

  typedef struct packed {
    logic                     en;
    logic                     sig_rd;
    logic                     fl_rd;
    logic                     page_write_bit;
    logic                     erase;
    logic [2:0]               win;
    fsp_op_t                  op;
    logic [FSP_PAGE_BITS-1:0] page;
    logic [1:0]               lock;
    logic [1:0]               lock_new;
    logic                     lock_loaded;
    logic                     prog_lock;
    logic                     read_lock;
    logic                     stall;
    logic [7:0]               rdata;
    logic                     ld_valid;
    logic [7:0]               ld_data;
  } fsp_ctl_t;

  fsp_ctl_t s_ff;
  fsp_ctl_t nxt_s;

  logic buf_clr;
  logic buf_we;
  logic buf_any;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic csr_wr;
  logic store_hit;
  logic load_hit;
  logic prog_ok;

  // Protection level: 0 none, 1 programming locked, 2 reading locked too
  function automatic logic [1:0] lock_level(input logic [1:0] lb);
    case (lb)
      2'h3:    lock_level = 2'h0;
      2'h2:    lock_level = 2'h1;
      default: lock_level = 2'h2;
    endcase
  endfunction

  // Lower or equal request falls to maximum protection
  function automatic logic [1:0] lock_merge(input logic [1:0] cur,
                                            input logic [1:0] req);
    if (lock_level(req) > lock_level(cur)) begin
      lock_merge = req;
    end else begin
      lock_merge = FSP_LOCK_MAX;
    end
  endfunction

  function automatic logic [7:0] csr_image(input fsp_ctl_t c);
    csr_image                  = FSP_CSR_RESET;
    csr_image[FSP_BIT_EN]      = c.en;
    csr_image[FSP_BIT_ERASE]   = c.erase;
    csr_image[FSP_BIT_PAGE_WRITE_BIT]   = c.page_write_bit;
    csr_image[FSP_BIT_FLREAD]  = c.fl_rd;
    csr_image[FSP_BIT_SIGREAD] = c.sig_rd;
  endfunction

  fsp_page_buffer u_buf (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clr        (buf_clr),
    .we         (buf_we),
    .waddr      (core_req.ptr[FSP_WORD_LSB +: FSP_WORD_BITS]),
    .wdata      (core_req.pair),
    .any_loaded (buf_any),
    .raddr      (flash_buf_addr),
    .rdata      (flash_buf_data)
  );

  fsp_op_timer #(
    .TICKS (OP_TICKS)
  ) u_tmr (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (tmr_start),
    .osc_tick (osc_tick),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  always_comb begin
    nxt_s          = s_ff;
    buf_clr        = 1'b0;
    buf_we         = 1'b0;
    tmr_start      = 1'b0;
    nxt_s.ld_valid = 1'b0;
    nxt_s.ld_data  = 8'h00;
    csr_wr    = reg_req.wr && reg_req.addr == FSP_CSR_OFF;
    store_hit = core_req.store && s_ff.en && s_ff.win != 3'h0 &&
                s_ff.op == FSP_OP_IDLE;
    load_hit  = core_req.load && s_ff.en && s_ff.win >= FSP_LOAD_MIN_WIN &&
                s_ff.op == FSP_OP_IDLE;
    prog_ok   = !self_program_fuse && !eeprom_write_busy_flag;

    // top bits read zero, unmapped reads zero
    nxt_s.rdata = (reg_req.rd && reg_req.addr == FSP_CSR_OFF) ?
                  csr_image(s_ff) : 8'h00;

    // Lock bits are nonvolatile, so they are fetched after reset release
    if (!s_ff.lock_loaded) begin
      nxt_s.lock        = lock_nv;
      nxt_s.lock_loaded = 1'b1;
    end else if (chip_erase && s_ff.op == FSP_OP_IDLE) begin
      nxt_s.lock = FSP_LOCK_NONE;
    end

    if (s_ff.op == FSP_OP_IDLE && s_ff.win != 3'h0) begin
      nxt_s.win = s_ff.win - 3'h1;
      if (s_ff.win == 3'h1) begin
        nxt_s.en     = 1'b0;
        nxt_s.sig_rd = 1'b0;
        nxt_s.fl_rd  = 1'b0;
        nxt_s.page_write_bit  = 1'b0;
        nxt_s.erase  = 1'b0;
      end
    end

    if (eeprom_write_start && buf_any) begin
      buf_clr = 1'b1;
    end

    // register writes refused while EEPROM programs or flash busy
    if (csr_wr && !eeprom_write_busy_flag && s_ff.op == FSP_OP_IDLE) begin
      if (reg_req.wdata[FSP_BIT_BUFCLR]) begin
        buf_clr = 1'b1;
      end
      nxt_s.en     = reg_req.wdata[FSP_BIT_EN];
      nxt_s.erase  = reg_req.wdata[FSP_BIT_ERASE];
      nxt_s.page_write_bit  = reg_req.wdata[FSP_BIT_PAGE_WRITE_BIT];
      nxt_s.fl_rd  = reg_req.wdata[FSP_BIT_FLREAD];
      nxt_s.sig_rd = reg_req.wdata[FSP_BIT_SIGREAD];
      nxt_s.win    = reg_req.wdata[FSP_BIT_EN] ? FSP_STORE_WIN : 3'h0;
    end

    if (store_hit) begin
      nxt_s.en     = 1'b0;
      nxt_s.sig_rd = 1'b0;
      nxt_s.fl_rd  = 1'b0;
      nxt_s.page_write_bit  = 1'b0;
      nxt_s.erase  = 1'b0;
      nxt_s.win    = 3'h0;
      if (prog_ok) begin
        case ({s_ff.sig_rd, s_ff.fl_rd, s_ff.page_write_bit, s_ff.erase})
          4'h1: begin
            nxt_s.op    = FSP_OP_ERASE;
            nxt_s.page  = core_req.ptr[FSP_PAGE_LSB +: FSP_PAGE_BITS] &
                          ~{{(FSP_PAGE_BITS-2){1'b0}}, 2'h3};
            nxt_s.en    = 1'b1;
            nxt_s.erase = 1'b1;
            tmr_start   = 1'b1;
          end
          4'h2: begin
            nxt_s.op    = FSP_OP_WRITE;
            nxt_s.page  = core_req.ptr[FSP_PAGE_LSB +: FSP_PAGE_BITS];
            nxt_s.en    = 1'b1;
            nxt_s.page_write_bit = 1'b1;
            tmr_start   = 1'b1;
          end
          4'h4: begin
            nxt_s.op       = FSP_OP_LOCK;
            nxt_s.lock_new = lock_merge(s_ff.lock, core_req.pair[1:0]);
            nxt_s.en       = 1'b1;
            nxt_s.fl_rd    = 1'b1;
            tmr_start      = 1'b1;
          end
          4'h0: begin
            buf_we = 1'b1;
          end
          default: begin
            buf_we = 1'b0;
          end
        endcase
      end
    end

    // Reads of fuse or signature consume the enable like a store does
    if (load_hit && (s_ff.sig_rd || s_ff.fl_rd)) begin
      nxt_s.en     = 1'b0;
      nxt_s.sig_rd = 1'b0;
      nxt_s.fl_rd  = 1'b0;
      nxt_s.win    = 3'h0;
      if (s_ff.sig_rd) begin
        nxt_s.ld_valid = 1'b1;
        nxt_s.ld_data  = FSP_SIG_DEFAULT;
      end else if (!eeprom_write_busy_flag) begin
        // lock or fuse by pointer bit 0
        nxt_s.ld_valid = 1'b1;
        if (core_req.ptr[0]) begin
          nxt_s.ld_data = {6'h3f, s_ff.lock};
        end else begin
          nxt_s.ld_data = core_req.ptr[1] ? fuse_high : fuse_low;
        end
      end
    end

    if (tmr_done && s_ff.op != FSP_OP_IDLE) begin
      nxt_s.op    = FSP_OP_IDLE;
      nxt_s.en    = 1'b0;
      nxt_s.page_write_bit = 1'b0;
      nxt_s.erase = 1'b0;
      nxt_s.fl_rd = 1'b0;
      if (s_ff.op == FSP_OP_WRITE) begin
        buf_clr = 1'b1;
      end
      if (s_ff.op == FSP_OP_LOCK) begin
        nxt_s.lock = s_ff.lock_new;
      end
    end

    nxt_s.prog_lock = lock_level(nxt_s.lock) != 2'h0;
    nxt_s.read_lock = lock_level(nxt_s.lock) == 2'h2;
    nxt_s.stall     = nxt_s.op == FSP_OP_ERASE || nxt_s.op == FSP_OP_WRITE;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_ff          <= '0;
      s_ff.op       <= FSP_OP_IDLE;
      s_ff.lock     <= FSP_LOCK_NONE;
      s_ff.lock_new <= FSP_LOCK_NONE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata      = s_ff.rdata;
  assign core_stall     = s_ff.stall;
  assign load_valid     = s_ff.ld_valid;
  assign load_data      = s_ff.ld_data;
  assign flash_cmd      = '{op:   s_ff.op,
                            page: s_ff.page};
  assign lock_bits      = s_ff.lock;
  assign ext_prog_lock  = s_ff.prog_lock;
  assign ext_read_lock  = s_ff.read_lock;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_stall;
    (s_ff.op == FSP_OP_ERASE || s_ff.op == FSP_OP_WRITE) |-> core_stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("core not stalled during operation");

  property p_erase_page;
    s_ff.op == FSP_OP_ERASE |-> s_ff.page[1:0] == 2'h0;
  endproperty
  a_erase_page: assert property (p_erase_page)
    else $error("erase page keeps low bits");

  property p_top_zero;
    $past(reg_req.rd) |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("reserved bits read nonzero");

  property p_window;
    (csr_wr && reg_req.wdata == 8'h01 && !eeprom_write_busy_flag &&
     s_ff.op == FSP_OP_IDLE) ##1 (!core_req.store && !core_req.load &&
     !reg_req.wr)[*4] |=> !s_ff.en;
  endproperty
  a_window: assert property (p_window)
    else $error("enable outlived its window");

  property p_en_held;
    s_ff.op != FSP_OP_IDLE |-> s_ff.en;
  endproperty
  a_en_held: assert property (p_en_held)
    else $error("enable dropped during operation");

  property p_fuse_gate;
    (core_req.store && self_program_fuse && s_ff.op == FSP_OP_IDLE) |=>
      s_ff.op == FSP_OP_IDLE;
  endproperty
  a_fuse_gate: assert property (p_fuse_gate)
    else $error("store acted with fuse unprogrammed");

  property p_ee_block;
    (core_req.store && eeprom_write_busy_flag && s_ff.op == FSP_OP_IDLE)
      |=> s_ff.op == FSP_OP_IDLE;
  endproperty
  a_ee_block: assert property (p_ee_block)
    else $error("programming during EEPROM write");

  property p_wr_clears;
    (s_ff.op == FSP_OP_WRITE ##1 s_ff.op == FSP_OP_IDLE) |-> !buf_any;
  endproperty
  a_wr_clears: assert property (p_wr_clears)
    else $error("buffer not cleared after page write");

  property p_erase_start;
    (store_hit && prog_ok && s_ff.erase && !s_ff.page_write_bit && !s_ff.fl_rd &&
     !s_ff.sig_rd) |=> s_ff.op == FSP_OP_ERASE ##1 core_stall;
  endproperty
  a_erase_start: assert property (p_erase_start)
    else $error("erase did not start");

  property p_lock_up;
    s_ff.lock_loaded && !chip_erase && s_ff.op == FSP_OP_IDLE |=>
      lock_level(s_ff.lock) >= $past(lock_level(s_ff.lock));
  endproperty
  a_lock_up: assert property (p_lock_up)
    else $error("protection level lowered");

endmodule
`default_nettype wire

/* File: logic/fsp_pkg.sv */
// Shared constants and types for the flash self-programming control block.
// Assumes a core that issues one store or load request per cycle at most.
package fsp_pkg;

  // Control and status register, one byte on a 6-bit register address
  localparam logic [5:0] FSP_CSR_OFF      = 6'h10;
  localparam int         FSP_BIT_EN       = 0;
  localparam int         FSP_BIT_ERASE    = 1;
  localparam int         FSP_BIT_PAGE_WRITE_BIT    = 2;
  localparam int         FSP_BIT_FLREAD   = 3;
  localparam int         FSP_BIT_BUFCLR   = 4;
  localparam int         FSP_BIT_SIGREAD  = 5;
  localparam logic [7:0] FSP_CSR_RESET    = 8'h00;

  // Window after a register write, counted down once per cycle
  localparam logic [2:0] FSP_STORE_WIN    = 3'h4;
  localparam logic [2:0] FSP_LOAD_MIN_WIN = 3'h2;

  // Pointer layout: bit 0 byte select, then word-in-page, then page
  localparam int         FSP_WORD_BITS    = 3;
  localparam int         FSP_PAGE_BITS    = 9;
  localparam int         FSP_WORD_LSB     = 1;
  localparam int         FSP_PAGE_LSB     = FSP_WORD_LSB + FSP_WORD_BITS;
  localparam int         FSP_PAGE_WORDS   = 1 << FSP_WORD_BITS;

  // Lock bits, 0 means programmed
  localparam logic [1:0] FSP_LOCK_NONE    = 2'h3;
  localparam logic [1:0] FSP_LOCK_MAX     = 2'h0;
  localparam logic [15:0] FSP_BUF_ERASED  = 16'hffff;
  // Signature table contents are not modelled; value is arbitrary
  localparam logic [7:0] FSP_SIG_DEFAULT  = 8'hff;

  // Operation time, timed by the 8 MHz calibrated oscillator
  localparam real        FSP_OP_MIN_MS    = 3.7;
  localparam real        FSP_OP_MAX_MS    = 4.5;
  localparam real        FSP_OSC_MHZ      = 8.0;
  localparam int unsigned FSP_OP_MIN_TICKS =
    int'($ceil(FSP_OP_MIN_MS * FSP_OSC_MHZ * 1000.0));
  localparam int unsigned FSP_OP_MAX_TICKS =
    int'($floor(FSP_OP_MAX_MS * FSP_OSC_MHZ * 1000.0));

  typedef enum logic [1:0] {
    FSP_OP_IDLE,
    FSP_OP_ERASE,
    FSP_OP_WRITE,
    FSP_OP_LOCK
  } fsp_op_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } fsp_reg_req_t;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] ptr;
    logic [15:0] pair;
  } fsp_core_req_t;

  typedef struct packed {
    fsp_op_t                  op;
    logic [FSP_PAGE_BITS-1:0] page;
  } fsp_flash_cmd_t;

endpackage

/* File: logic/fsp_op_timer.sv */
// Flash operation timer, counting ticks of the calibrated oscillator.
// Assumes osc_tick is a one-cycle pulse synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module fsp_op_timer #(
  parameter int unsigned TICKS = fsp_pkg::FSP_OP_MIN_TICKS
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic osc_tick,
  output logic      busy,
  output logic      done
);
  import fsp_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [15:0] cnt;
  } fsp_tmr_t;

  fsp_tmr_t s_ff;
  fsp_tmr_t nxt_s;

  // One extra tick because the first one may arrive right after start
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (start) begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt  = TICKS[15:0] + 16'h1;
    end else if (s_ff.busy && osc_tick) begin
      if (s_ff.cnt == 16'h1) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
      nxt_s.cnt = s_ff.cnt - 16'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign busy = s_ff.busy;
  assign done = s_ff.done;
endmodule
`default_nettype wire

/* File: logic/fsp_page_buffer.sv */
// Temporary page buffer, one word per location, with a loaded map.
// Assumes each location is loaded once between clears.
`timescale 1ns/100ps
`default_nettype none
module fsp_page_buffer (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // Load side
  input  wire logic                             clr,
  input  wire logic                             we,
  input  wire logic [fsp_pkg::FSP_WORD_BITS-1:0] waddr,
  input  wire logic [15:0]                      wdata,
  output logic                                  any_loaded,
  // Flash side
  input  wire logic [fsp_pkg::FSP_WORD_BITS-1:0] raddr,
  output logic [15:0]                           rdata
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [FSP_PAGE_WORDS-1:0] loaded;
    logic [15:0]               rdata;
  } fsp_buf_t;

  fsp_buf_t    s_ff;
  fsp_buf_t    nxt_s;
  logic [15:0] mem [FSP_PAGE_WORDS];

  // Clearing only drops the loaded map, so a clear costs one cycle
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.rdata = s_ff.loaded[raddr] ? mem[raddr] : FSP_BUF_ERASED;
    if (clr) begin
      nxt_s.loaded = '0;
    end
    // A word stored in the clearing cycle survives the clear
    if (we) begin
      nxt_s.loaded[waddr] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign any_loaded = |s_ff.loaded;
  assign rdata      = s_ff.rdata;
endmodule
`default_nettype wire

/* File: verification/fsp_core_model.sv */
// Core model: issues store and load instructions to the block.
// Assumes the bench calls it right after a register write.
`timescale 1ns/100ps
`default_nettype none
module fsp_core_model (
  // Clock
  input  wire logic                  sys_clk,
  // Core side
  input  wire logic                  core_stall,
  output var fsp_pkg::fsp_core_req_t core_req
);
  import fsp_pkg::*;

  initial core_req = '0;

  // halted core waits, then issues in window
  task automatic issue(input logic st, input logic [15:0] p, d);
    @(posedge sys_clk);
    while (core_stall === 1'b1) @(posedge sys_clk);
    core_req <= '{store: st, load: !st, ptr: p, pair: d};
    @(posedge sys_clk);
    // Idle lines show the inverse so stale values cannot pass
    core_req <= '{store: 1'b0, load: 1'b0, ptr: ~p, pair: ~d};
  endtask
endmodule
`default_nettype wire

/* File: verification/fsp_self_program_tb_top.sv */
// Testbench for the flash self-programming control block.
// Assumes one oscillator tick every second cycle and a short op count.
`timescale 1ns/100ps
`default_nettype none
module fsp_self_program_tb_top;
  import fsp_pkg::*;
  localparam int unsigned T = 20;
  logic           sys_clk;
  logic           rst;
  logic           osc_tick;
  fsp_reg_req_t   reg_req;
  logic [7:0]     reg_rdata;
  fsp_core_req_t  core_req;
  logic           core_stall;
  logic           load_valid;
  logic [7:0]     load_data;
  logic           ee_busy;
  logic           ee_start;
  logic           fuse_n;
  logic           chip_erase;
  fsp_flash_cmd_t flash_cmd;
  logic [1:0]     lock_bits;
  logic           ext_prog_lock;
  logic           ext_read_lock;
  logic [2:0]     flash_buf_addr;
  logic [15:0]    flash_buf_data;
  int             n_errors;
  int             total_checks;
  int             cyc;
  int             n;

  fsp_self_program #(.OP_TICKS(T)) fsp_self_program_i (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .core_req(core_req), .core_stall(core_stall),
    .load_valid(load_valid), .load_data(load_data),
    .eeprom_write_busy_flag(ee_busy), .eeprom_write_start(ee_start),
    .osc_tick(osc_tick), .self_program_fuse(fuse_n), .fuse_low(8'h5a),
    .fuse_high(8'ha5), .lock_nv(2'h3), .chip_erase(chip_erase),
    .flash_cmd(flash_cmd), .lock_bits(lock_bits),
    .ext_prog_lock(ext_prog_lock), .ext_read_lock(ext_read_lock),
    .flash_buf_addr(flash_buf_addr), .flash_buf_data(flash_buf_data));

  fsp_core_model fsp_core_model_i (
    .sys_clk(sys_clk), .core_stall(core_stall), .core_req(core_req));

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: FSP_CSR_OFF, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic st(input logic [15:0] p, d);
    fsp_core_model_i.issue(1'b1, p, d);
    #1;
  endtask

  task automatic ld(input logic [15:0] p, input logic [7:0] e);
    fsp_core_model_i.issue(1'b0, p, 16'h0000);
    #1 chk(load_valid, 1'b1);
    chk(load_data, e);
  endtask

  task automatic bchk(input logic [2:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    flash_buf_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 chk(flash_buf_data, e);
  endtask

  // Counts cycles the op stands, checking the stall level meanwhile
  task automatic wait_op(input logic s);
    n = 1;
    while (n < 200) begin
      @(posedge sys_clk);
      #1;
      if (flash_cmd.op === FSP_OP_IDLE) break;
      chk(core_stall, s);
      n++;
    end
  endtask

  task automatic t_reset();
    rd(FSP_CSR_OFF, FSP_CSR_RESET);
    rd(6'h11, 8'h00);
    chk({ext_read_lock, ext_prog_lock, lock_bits}, 4'h3);
  endtask

  task automatic t_load_write();
    wr(8'h01);
    st(16'h0007, 16'h1234);
    bchk(3'h3, 16'h1234);
    bchk(3'h2, FSP_BUF_ERASED);
    wr(8'h05);
    st(16'h0050, 16'h0000);
    chk({flash_cmd.op, flash_cmd.page}, {FSP_OP_WRITE, 9'h005});
    chk(core_stall, 1'b1);
    rd(FSP_CSR_OFF, 8'h05);
    wait_op(1'b1);
    rd(FSP_CSR_OFF, 8'h00);
    bchk(3'h3, FSP_BUF_ERASED);
  endtask

  task automatic t_erase();
    wr(8'h03);
    st(16'heabf, 16'h5a5a);
    chk({flash_cmd.op, flash_cmd.page}, {FSP_OP_ERASE, 9'h0a8});
    wait_op(1'b1);
    // T+1 ticks, one every second cycle, then one edge to go idle
    chk(n >= 2 * T + 2 && n <= 2 * T + 3, 1'b1);
    chk(core_stall, 1'b0);
  endtask

  task automatic t_lapse();
    wr(8'h01);
    repeat (3) @(posedge sys_clk);
    st(16'h0002, 16'hbeef);
    chk(flash_cmd.op, FSP_OP_IDLE);
    bchk(3'h1, FSP_BUF_ERASED);
    rd(FSP_CSR_OFF, 8'h00);
    wr(8'h05);
    repeat (3) @(posedge sys_clk);
    rd(FSP_CSR_OFF, 8'h00);
    wr(8'hc1);
    rd(FSP_CSR_OFF, 8'h01);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_clear();
    wr(8'h01);
    st(16'h0004, 16'h1111);
    bchk(3'h2, 16'h1111);
    wr(8'h10);
    bchk(3'h2, FSP_BUF_ERASED);
    wr(8'h01);
    st(16'h0008, 16'h2222);
    @(posedge sys_clk);
    ee_start <= 1'b1;
    @(posedge sys_clk);
    ee_start <= 1'b0;
    bchk(3'h4, FSP_BUF_ERASED);
  endtask

  task automatic t_busy();
    wr(8'h01);
    @(posedge sys_clk);
    ee_busy <= 1'b1;
    st(16'h000c, 16'h3333);
    bchk(3'h6, FSP_BUF_ERASED);
    wr(8'h01);
    rd(FSP_CSR_OFF, 8'h00);
    @(posedge sys_clk);
    ee_busy <= 1'b0;
  endtask

  task automatic t_reads();
    wr(8'h21);
    ld(16'h0000, FSP_SIG_DEFAULT);
    wr(8'h09);
    ld(16'h0000, 8'h5a);
    wr(8'h09);
    ld(16'h0002, 8'ha5);
    wr(8'h09);
    ld(16'h0001, 8'hff);
  endtask

  task automatic t_lock();
    wr(8'h09);
    st(16'h0000, 16'h0002);
    chk(flash_cmd.op, FSP_OP_LOCK);
    wait_op(1'b0);
    @(posedge sys_clk);
    #1 chk({ext_read_lock, ext_prog_lock, lock_bits}, 4'h6);
    wr(8'h09);
    ld(16'h0001, 8'hfe);
    wr(8'h09);
    st(16'h0000, 16'h0002);
    wait_op(1'b0);
    @(posedge sys_clk);
    #1 chk({ext_read_lock, ext_prog_lock, lock_bits}, 4'hc);
    @(posedge sys_clk);
    chip_erase <= 1'b1;
    @(posedge sys_clk);
    chip_erase <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({ext_read_lock, ext_prog_lock, lock_bits}, 4'h3);
  endtask

  task automatic t_fuse_rst();
    @(posedge sys_clk);
    fuse_n <= 1'b1;
    wr(8'h01);
    st(16'h000e, 16'h4444);
    bchk(3'h7, FSP_BUF_ERASED);
    @(posedge sys_clk);
    fuse_n <= 1'b0;
    wr(8'h01);
    st(16'h000a, 16'h5555);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bchk(3'h5, FSP_BUF_ERASED);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Whole run needs about 320 cycles
  always @(posedge sys_clk) begin
    osc_tick <= ~osc_tick;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    cyc = 0;
    rst = 1'b1;
    osc_tick = 1'b0;
    reg_req = '0;
    ee_busy = 1'b0;
    ee_start = 1'b0;
    fuse_n = 1'b0;
    chip_erase = 1'b0;
    flash_buf_addr = 3'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_load_write();
    t_erase();
    t_lapse();
    t_clear();
    t_busy();
    t_reads();
    t_lock();
    t_fuse_rst();
    conclude();
  end
endmodule
`default_nettype wire
